// file: core/ubrg_pkg.sv
// Shared constants and types for the serial port rate generator
package ubrg_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;
  localparam int POST_W = 7;
  localparam int SYNC_STAGES = 2;

  // Register indices on the local register port
  localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_BAUD_CTRL = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_DIV_LOW = 3'h4;

  // Field positions
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HIGH_SPEED_BIT = 2;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  localparam int RX_ENABLE_BIT = 7;
  localparam int BAUD_LINE_IDLE_BIT = 6;
  localparam int BAUD_WIDE_BIT = 3;

  // Writable bit masks; other bits are status or unimplemented
  localparam logic [DATA_W-1:0] TX_CTRL_WMASK = 8'hFD;
  localparam logic [DATA_W-1:0] RX_CTRL_WMASK = 8'hF8;
  localparam logic [DATA_W-1:0] BAUD_CTRL_WMASK = 8'h1B;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIV_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [POST_W-1:0] POST_ZERO = 7'h00;
  localparam logic [POST_W-1:0] POST_ONE = 7'h01;
  localparam logic [POST_W-1:0] POST_TWO = 7'h02;

  // Base-tick counts per bit period
  localparam logic [POST_W-1:0] POST_SYNC = 7'h04;
  localparam logic [POST_W-1:0] POST_ASYNC_WIDE_FAST = 7'h04;
  localparam logic [POST_W-1:0] POST_ASYNC_WIDE_SLOW = 7'h10;
  localparam logic [POST_W-1:0] POST_ASYNC_NARROW_FAST = 7'h10;
  localparam logic [POST_W-1:0] POST_ASYNC_NARROW_SLOW = 7'h40;

  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic high_speed_select;
    logic wide_divisor_select;
  } ubrg_cfg_t;

endpackage : ubrg_pkg

// file: core/ubrg_vote.sv
// Three-sample majority detector for the receive line
`timescale 1ns/1ps
module ubrg_vote (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic sample_i,
  input wire logic last_i,
  input wire logic line_i,
  output logic bit_o,
  output logic valid_o
);
  import ubrg_pkg::*;

  logic [1:0] early;
  logic [1:0] next_early;
  logic bit_q;
  logic next_bit;
  logic valid_q;
  logic next_valid;

  always_comb begin
    next_early = early;
    next_bit = bit_q;
    next_valid = 1'b0;
    if (clear_i) begin
      next_early = 2'b11;
    end else if (sample_i && last_i) begin
      // Majority of the two held samples and the current one
      next_bit = (early[0] & early[1]) | (early[0] & line_i) | (early[1] & line_i);
      next_valid = 1'b1;
    end else if (sample_i) begin
      next_early = {early[0], line_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      early <= 2'b11;
      bit_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      early <= next_early;
      bit_q <= next_bit;
      valid_q <= next_valid;
    end
  end

  assign bit_o = bit_q;
  assign valid_o = valid_q;

endmodule : ubrg_vote

// file: core/ubrg_top.sv
// Rate generator and receive-line sampler of the enhanced serial port
//
// Functional notes
// - Every bit-rate tick is derived from the one system clock.
// - Receive line sampled three times per bit; majority decides the level.
// - Async, 8-bit divisor, low speed: clock over 64 times (n+1).
// - Async, 16-bit divisor, low speed: clock over 16 times (n+1).
// - Synchronous mode: clock over 4 times (n+1), either divisor width.
// - n is high byte joined to low byte with the 16-bit divisor, low byte alone with the 8-bit one; high speed ignored when synchronous.
// - Divisor lives in two 8-bit software registers, high and low.
// - Narrow mode uses only the low divisor byte, high byte ignored.
// - Any divisor write clears the running count at once.
// - Free-running period timer serves async and synchronous operation.
`timescale 1ns/1ps
module ubrg_top #(
  parameter int DIV_WIDTH = ubrg_pkg::DIV_W
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [ubrg_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [ubrg_pkg::DATA_W-1:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic RX_I,
  output logic [ubrg_pkg::DATA_W-1:0] RD_DATA_O,
  output logic BASE_TICK_O,
  output logic BIT_TICK_O,
  output logic RX_BIT_O,
  output logic RX_VALID_O
);
  import ubrg_pkg::*;

  // Software-visible register state
  logic [DATA_W-1:0] tx_ctrl;
  logic [DATA_W-1:0] rx_ctrl;
  logic [DATA_W-1:0] baud_ctrl;
  logic [DATA_W-1:0] div_high;
  logic [DATA_W-1:0] div_low;
  logic [DATA_W-1:0] next_tx_ctrl;
  logic [DATA_W-1:0] next_rx_ctrl;
  logic [DATA_W-1:0] next_baud_ctrl;
  logic [DATA_W-1:0] next_div_high;
  logic [DATA_W-1:0] next_div_low;
  logic div_write;

  // Read port
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;

  // Rate generator
  ubrg_cfg_t cfg;
  logic [DIV_WIDTH-1:0] reload;
  logic [DIV_WIDTH-1:0] count;
  logic [DIV_WIDTH-1:0] next_count;
  logic [POST_W-1:0] post;
  logic [POST_W-1:0] next_post;
  logic [POST_W-1:0] post_len;
  logic [POST_W-1:0] post_mid;
  logic base_tick;
  logic next_base_tick;
  logic bit_tick;
  logic next_bit_tick;
  logic gen_clear;
  logic base_due;

  // Receive line
  logic [SYNC_STAGES-1:0] rx_sync;
  logic rx_line;
  logic sample_en;
  logic sample_last;
  logic voted_bit;
  logic voted_valid;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  always_comb begin
    next_tx_ctrl = tx_ctrl;
    next_rx_ctrl = rx_ctrl;
    next_baud_ctrl = baud_ctrl;
    next_div_high = div_high;
    next_div_low = div_low;
    div_write = 1'b0;
    if (WR_I) begin
      unique case (ADDR_I)
        ADDR_TX_CTRL: begin
          next_tx_ctrl = WR_DATA_I & TX_CTRL_WMASK;
        end
        ADDR_RX_CTRL: begin
          next_rx_ctrl = WR_DATA_I & RX_CTRL_WMASK;
        end
        ADDR_BAUD_CTRL: begin
          next_baud_ctrl = WR_DATA_I & BAUD_CTRL_WMASK;
        end
        ADDR_DIV_HIGH: begin
          next_div_high = WR_DATA_I;
          div_write = 1'b1;
        end
        ADDR_DIV_LOW: begin
          next_div_low = WR_DATA_I;
          div_write = 1'b1;
        end
        default: begin
          // Writes to unmapped indices are dropped
          div_write = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      tx_ctrl <= CTRL_RESET;
      rx_ctrl <= CTRL_RESET;
      baud_ctrl <= CTRL_RESET;
      div_high <= DIV_RESET;
      div_low <= DIV_RESET;
    end else begin
      tx_ctrl <= next_tx_ctrl;
      rx_ctrl <= next_rx_ctrl;
      baud_ctrl <= next_baud_ctrl;
      div_high <= next_div_high;
      div_low <= next_div_low;
    end
  end

  // ---------------------------------------------------------------
  // Read data, valid in the cycle after the strobe only
  // ---------------------------------------------------------------
  always_comb begin
    next_rd_data = READ_ZERO;
    if (RD_I) begin
      unique case (ADDR_I)
        ADDR_TX_CTRL: begin
          // The shift register lives elsewhere; it reads as empty here
          next_rd_data = tx_ctrl;
          next_rd_data[TX_SHIFT_EMPTY_BIT] = 1'b1;
        end
        ADDR_RX_CTRL: begin
          next_rd_data = rx_ctrl;
        end
        ADDR_BAUD_CTRL: begin
          next_rd_data = baud_ctrl;
          next_rd_data[BAUD_LINE_IDLE_BIT] = voted_bit;
        end
        ADDR_DIV_HIGH: begin
          next_rd_data = div_high;
        end
        ADDR_DIV_LOW: begin
          next_rd_data = div_low;
        end
        default: begin
          next_rd_data = READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rd_data <= READ_ZERO;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  always_comb begin
    cfg.enable = rx_ctrl[RX_ENABLE_BIT];
    cfg.sync_mode = tx_ctrl[TX_SYNC_BIT];
    cfg.high_speed_select = tx_ctrl[TX_HIGH_SPEED_BIT];
    cfg.wide_divisor_select = baud_ctrl[BAUD_WIDE_BIT];
  end

  always_comb begin
    if (cfg.wide_divisor_select) begin
      reload = DIV_WIDTH'({div_high, div_low});
    end else begin
      reload = DIV_WIDTH'(div_low);
    end
  end

  // Base ticks per bit: the fixed prescale of each formula
  always_comb begin
    if (cfg.sync_mode) begin
      post_len = POST_SYNC;
    end else if (cfg.wide_divisor_select) begin
      if (cfg.high_speed_select) begin
        post_len = POST_ASYNC_WIDE_FAST;
      end else begin
        post_len = POST_ASYNC_WIDE_SLOW;
      end
    end else begin
      if (cfg.high_speed_select) begin
        post_len = POST_ASYNC_NARROW_FAST;
      end else begin
        post_len = POST_ASYNC_NARROW_SLOW;
      end
    end
    post_mid = post_len >> 1;
  end

  // ---------------------------------------------------------------
  // Free-running period timer
  // ---------------------------------------------------------------
  // Up-counting so a cleared count gives a full new period at once;
  // the >= compare also covers a reload shrinking under a running count.
  // The rate follows MCLK_I directly: after a switch of clock source the
  // divisor pair needs a reload from software to keep the bit rate.
  assign gen_clear = div_write || !cfg.enable;

  // One base period has elapsed in this cycle
  assign base_due = !gen_clear && count >= reload;

  always_comb begin
    next_count = count;
    next_post = post;
    next_base_tick = 1'b0;
    next_bit_tick = 1'b0;
    if (gen_clear) begin
      next_count = COUNT_ZERO;
      next_post = POST_ZERO;
    end else if (base_due) begin
      next_count = COUNT_ZERO;
      next_base_tick = 1'b1;
      if (post >= post_len - POST_ONE) begin
        next_post = POST_ZERO;
        next_bit_tick = 1'b1;
      end else begin
        next_post = post + POST_ONE;
      end
    end else begin
      next_count = count + DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      count <= COUNT_ZERO;
      post <= POST_ZERO;
      base_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      count <= next_count;
      post <= next_post;
      base_tick <= next_base_tick;
      bit_tick <= next_bit_tick;
    end
  end

  // ---------------------------------------------------------------
  // Receive line: two-stage synchroniser, then majority sampling
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rx_sync <= {SYNC_STAGES{1'b1}};
    end else begin
      rx_sync <= {rx_sync[SYNC_STAGES-2:0], RX_I};
    end
  end

  assign rx_line = rx_sync[SYNC_STAGES-1];

  // Three samples around mid-bit on consecutive base ticks. The vote runs
  // free and is not aligned to a start bit; a framing receiver must clear
  // the generator on its start edge to centre the samples.
  always_comb begin
    sample_en = 1'b0;
    sample_last = 1'b0;
    if (base_due) begin
      if (post == post_mid - POST_TWO || post == post_mid - POST_ONE) begin
        sample_en = 1'b1;
      end else if (post == post_mid) begin
        sample_en = 1'b1;
        sample_last = 1'b1;
      end
    end
  end

  ubrg_vote u_vote (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .clear_i(gen_clear),
    .sample_i(sample_en),
    .last_i(sample_last),
    .line_i(rx_line),
    .bit_o(voted_bit),
    .valid_o(voted_valid)
  );

  assign RD_DATA_O = rd_data;
  assign BASE_TICK_O = base_tick;
  assign BIT_TICK_O = bit_tick;
  assign RX_BIT_O = voted_bit;
  assign RX_VALID_O = voted_valid;

endmodule : ubrg_top

// file: tb/ubrg_checker.sv
// Port-level properties of the serial port rate generator
`timescale 1ns/1ps
module ubrg_checker
  import ubrg_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic RX_I,
  input wire logic [DATA_W-1:0] RD_DATA_O,
  input wire logic BASE_TICK_O,
  input wire logic BIT_TICK_O,
  input wire logic RX_BIT_O,
  input wire logic RX_VALID_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  logic div_wr;
  logic off_wr;
  assign div_wr = WR_I && (ADDR_I == ADDR_DIV_HIGH || ADDR_I == ADDR_DIV_LOW);
  assign off_wr = WR_I && ADDR_I == ADDR_RX_CTRL && !WR_DATA_I[RX_ENABLE_BIT];
  rd_idle_a: assert property (!$past(RD_I) |-> RD_DATA_O == READ_ZERO)
    else $error("read data not idle");
  unmapped_a: assert property (RD_I && ADDR_I > ADDR_DIV_LOW |=> RD_DATA_O == READ_ZERO)
    else $error("unmapped read not zero");
  shift_empty_a: assert property (RD_I && ADDR_I == ADDR_TX_CTRL |=> RD_DATA_O[TX_SHIFT_EMPTY_BIT])
    else $error("shift empty bit low");
  bit_base_a: assert property (BIT_TICK_O |-> BASE_TICK_O)
    else $error("bit tick without base tick");
  bit_gap_a: assert property (BIT_TICK_O |=> !BIT_TICK_O [*3])
    else $error("bit ticks too close");
  vote_pulse_a: assert property (RX_VALID_O |=> !RX_VALID_O)
    else $error("vote valid too long");
  vote_hold_a: assert property (!RX_VALID_O |-> $stable(RX_BIT_O))
    else $error("voted bit moved without valid");
  wr_clear_a: assert property (div_wr |=> !BASE_TICK_O ##1 !BIT_TICK_O)
    else $error("tick right after divisor write");
  off_quiet_a: assert property (off_wr |=> ##1 !BASE_TICK_O [*3])
    else $error("tick while disabled");
  cover property (BIT_TICK_O);
  cover property (RX_VALID_O && !RX_BIT_O);
  cover property (div_wr);
endmodule : ubrg_checker

bind ubrg_top ubrg_checker #(.DIV_WIDTH(DIV_WIDTH)) chk (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I), .RX_I(RX_I),
  .RD_DATA_O(RD_DATA_O), .BASE_TICK_O(BASE_TICK_O), .BIT_TICK_O(BIT_TICK_O),
  .RX_BIT_O(RX_BIT_O), .RX_VALID_O(RX_VALID_O));

// file: tb/ubrg_top_bench.sv
// Self-checking bench for the serial port rate generator
`timescale 1ns/1ps
module ubrg_top_bench;
  import ubrg_pkg::*;
  logic MCLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [ADDR_W-1:0] ADDR_I = '0;
  logic [DATA_W-1:0] WR_DATA_I = '0;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic RX_I = 1'b1;
  logic [DATA_W-1:0] RD_DATA_O;
  logic BASE_TICK_O, BIT_TICK_O, RX_BIT_O, RX_VALID_O;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  ubrg_top DUT (.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RX_I(RX_I), .RD_DATA_O(RD_DATA_O),
    .BASE_TICK_O(BASE_TICK_O), .BIT_TICK_O(BIT_TICK_O), .RX_BIT_O(RX_BIT_O),
    .RX_VALID_O(RX_VALID_O));
  always #2.5 MCLK_I = ~MCLK_I;
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Worst-case run over all eight modes is about 60k cycles; the ceiling leaves margin
  always @(posedge MCLK_I) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n
  task automatic chk_b(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_b
  task automatic step();
    @(posedge MCLK_I);
    #1;
  endtask : step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge MCLK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WR_DATA_I <= d;
    @(posedge MCLK_I);
    WR_I <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge MCLK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge MCLK_I);
    RD_I <= 1'b0;
    #1;
    chk_b(RD_DATA_O, e);
  endtask : rd
  task automatic measure(output int per, output int base);
    per = 0;
    base = 0;
    do step(); while (BIT_TICK_O !== 1'b1);
    do begin
      step();
      per++;
      base += (BASE_TICK_O === 1'b1);
    end while (BIT_TICK_O !== 1'b1);
  endtask : measure
  initial begin
    int per, base, p, n, k;
    logic [DATA_W-1:0] hi, lo;
    logic s, w, h, rx;
    void'($urandom(76456));
    repeat (4) @(posedge MCLK_I);
    RST_I <= 1'b0;
    rd(ADDR_TX_CTRL, 8'h02);
    rd(3'h7, READ_ZERO);
    rd(ADDR_BAUD_CTRL, 8'h40);
    for (int i = 0; i < 8; i++) begin
      {s, w, h} = i[2:0];
      hi = 8'($urandom_range(1, 2));
      lo = 8'($urandom_range(0, 7));
      rx = 1'($urandom_range(0, 1));
      @(posedge MCLK_I) RX_I <= rx;
      // Mode changes only while stopped, so the postscaler never overruns
      wr(ADDR_RX_CTRL, 8'h00);
      wr(ADDR_TX_CTRL, {3'h0, s, 1'b0, h, 2'h0});
      wr(ADDR_BAUD_CTRL, {4'h0, w, 3'h0});
      wr(ADDR_DIV_HIGH, hi);
      wr(ADDR_DIV_LOW, lo);
      wr(ADDR_RX_CTRL, 8'h80);
      n = w ? int'({hi, lo}) : int'(lo);
      p = s ? 4 : w ? (h ? 4 : 16) : (h ? 16 : 64);
      measure(per, base);
      chk_n(base, p);
      chk_n(per, p * (n + 1));
      repeat (2) do step(); while (RX_VALID_O !== 1'b1);
      chk_b({7'h0, RX_BIT_O}, {7'h0, rx});
      rd(ADDR_BAUD_CTRL, {1'b0, rx, 2'h0, w, 3'h0});
      rd(ADDR_DIV_HIGH, hi);
      rd(ADDR_TX_CTRL, {3'h0, s, 1'b0, h, 2'h2});
      wr(ADDR_DIV_HIGH, hi);
      k = 0;
      do begin
        step();
        k++;
      end while (BASE_TICK_O !== 1'b1);
      chk_n(k, n + 1);
    end
    // Reset in mid-run must bring back the register reset values
    @(posedge MCLK_I);
    RST_I <= 1'b1;
    repeat (2) @(posedge MCLK_I);
    RST_I <= 1'b0;
    rd(ADDR_DIV_LOW, DIV_RESET);
    rd(ADDR_BAUD_CTRL, 8'h40);
    chk_b({7'h0, BASE_TICK_O}, 8'h00);
    tally_and_finish();
  end
endmodule : ubrg_top_bench
